/* pkg/mbl_pkg.sv */
// Package with constants and types of the memory bus lane steering block.
package mbl_pkg;
   localparam int MBL_IDX_W      = 4;
   localparam int MBL_REG_W      = 40;
   localparam int MBL_BUS_W      = 64;
   localparam int MBL_NW_W       = 32;
   localparam int MBL_SW_W       = 16;
   localparam int MBL_PAD_W      = 8;
   localparam int MBL_EXT_PAD_W  = 24;
   localparam int MBL_SW_IMP_LSB = 32;
   localparam int MBL_AXI_AW     = 8;

   localparam logic [7:0] MBL_CTRL_OFS = 8'h00;
   localparam logic [7:0] MBL_STAT_OFS = 8'h04;
   localparam logic [7:0] MBL_CNT_OFS  = 8'h08;
   localparam logic [7:0] MBL_SEL_OFS  = 8'h0C;
   localparam logic [7:0] MBL_RFLO_OFS = 8'h10;
   localparam logic [7:0] MBL_RFHI_OFS = 8'h14;

   localparam int MBL_CTRL_EN_BIT   = 2;
   localparam int MBL_STAT_EXT_BIT  = 0;
   localparam int MBL_STAT_CONF_BIT = 1;
   localparam int MBL_SEL_PE_BIT    = 4;

   localparam logic [1:0] MBL_MODE_RST = 2'h0;
   localparam logic       MBL_EN_RST   = 1'b1;
   localparam logic [1:0] MBL_RESP_OK  = 2'h0;
   localparam logic [1:0] MBL_RESP_ERR = 2'h2;

   typedef enum logic [1:0] {
      MBL_LW  = 2'b00,
      MBL_EXT = 2'b01,
      MBL_N32 = 2'b10,
      MBL_SW  = 2'b11
   } mbl_wtype_e;

   typedef enum logic [1:0] {
      MBL_SINGLE_DATA_PATH_MODE  = 2'b00,
      MBL_SIMD  = 2'b01,
      MBL_BCAST = 2'b10
   } mbl_mode_e;

   typedef struct packed {
      logic                 pe;
      logic [MBL_IDX_W-1:0] idx;
      mbl_wtype_e           wtype;
   } mbl_side_s;

   typedef struct packed {
      logic      store;
      logic      dual;
      logic      useDm;
      mbl_side_s pm;
      mbl_side_s dm;
   } mbl_cmd_s;

   typedef struct packed {
      logic [3:0]           en;
      logic [MBL_REG_W-1:0] named;
      logic [MBL_REG_W-1:0] neigh;
      logic [MBL_REG_W-1:0] compl;
      logic [MBL_REG_W-1:0] complNeigh;
   } mbl_load_s;
endpackage

/* verilog/mbl_lane_unpack.sv */
// Bus-to-register lane mapping for one data bus on a load.
`timescale 1ns/1ns
module mbl_lane_unpack
(
   input  wire logic [mbl_pkg::MBL_BUS_W-1:0] bus,
   input  wire mbl_pkg::mbl_wtype_e           wtype,
   input  wire mbl_pkg::mbl_mode_e            mode,
   output mbl_pkg::mbl_load_s                 ld
);
   import mbl_pkg::*;

   localparam int SW_TOP = MBL_REG_W - MBL_SW_W - MBL_PAD_W;

   always_comb
   begin
      ld = '0;
      case (wtype)
         MBL_LW:
         begin
            ld.named = {bus[MBL_NW_W-1:0], {MBL_PAD_W{1'b0}}};
            ld.neigh = {bus[MBL_BUS_W-1:MBL_NW_W], {MBL_PAD_W{1'b0}}};
            ld.en    = 4'b0011;
         end
         MBL_EXT:
         begin
            // SIMD is refused for this width, so it lands on one register unless broadcast also copies it.
            ld.named = bus[MBL_BUS_W-1:MBL_EXT_PAD_W];
            ld.en    = 4'b0001;
         end
         MBL_N32:
         begin
            ld.named = {bus[MBL_NW_W-1:0], {MBL_PAD_W{1'b0}}};
            ld.compl = {bus[MBL_BUS_W-1:MBL_NW_W], {MBL_PAD_W{1'b0}}};
            ld.en    = (mode == MBL_SIMD) ? 4'b0101 : 4'b0001;
         end
         MBL_SW:
         begin
            ld.named = {{SW_TOP{1'b0}}, bus[MBL_SW_W-1:0], {MBL_PAD_W{1'b0}}};
            ld.compl = {{SW_TOP{1'b0}}, bus[MBL_SW_IMP_LSB+MBL_SW_W-1:MBL_SW_IMP_LSB],
                        {MBL_PAD_W{1'b0}}};
            ld.en    = (mode == MBL_SIMD) ? 4'b0101 : 4'b0001;
         end
         default:
         begin
            ld.en = 4'b0000;
         end
      endcase
      // Broadcast copies the explicit words into the other element as well.
      if (mode == MBL_BCAST)
      begin
         ld.compl      = ld.named;
         ld.complNeigh = ld.neigh;
         ld.en[2]      = 1'b1;
         ld.en[3]      = ld.en[1];
      end
   end
endmodule

/* verilog/mbl_lane_pack.sv */
// Register-to-bus lane mapping for one data bus on a store.
`timescale 1ns/1ns
module mbl_lane_pack
(
   input  wire logic [mbl_pkg::MBL_REG_W-1:0] named,
   input  wire logic [mbl_pkg::MBL_REG_W-1:0] neigh,
   input  wire logic [mbl_pkg::MBL_REG_W-1:0] compl,
   input  wire mbl_pkg::mbl_wtype_e           wtype,
   input  wire logic                          simd,
   output logic [mbl_pkg::MBL_BUS_W-1:0]      bus
);
   import mbl_pkg::*;

   localparam int SW_HI = MBL_SW_W + MBL_PAD_W - 1;

   always_comb
   begin
      bus = '0;
      case (wtype)
         MBL_LW:
            bus = {neigh[MBL_REG_W-1:MBL_PAD_W], named[MBL_REG_W-1:MBL_PAD_W]};
         MBL_EXT:
            bus = {named, {MBL_EXT_PAD_W{1'b0}}};
         MBL_N32:
         begin
            bus[MBL_NW_W-1:0] = named[MBL_REG_W-1:MBL_PAD_W];
            if (simd)
               bus[MBL_BUS_W-1:MBL_NW_W] = compl[MBL_REG_W-1:MBL_PAD_W];
         end
         MBL_SW:
         begin
            bus[MBL_SW_W-1:0] = named[SW_HI:MBL_PAD_W];
            if (simd)
               bus[MBL_SW_IMP_LSB+MBL_SW_W-1:MBL_SW_IMP_LSB] = compl[SW_HI:MBL_PAD_W];
         end
         default:
            bus = '0;
      endcase
   end
endmodule

/* verilog/mbl_lane_steer.sv */
// Lane steering between the two memory data buses and the two register files.
// Notes on behaviour
// - Long word uses each data bus as one full 64-bit lane.
// - Single-data long word behaves the same in single-path and SIMD mode.
// - Long-word load fills the named register and its neighbor register.
// - Long-word load zeroes the eight low bits of both registers.
// - Extended word travels on the top 40 bits of its bus.
// - Extended transfers drive the low 24 bus bits with zeros.
// - Single-data extended access targets only the named register, except in broadcast mode.
// - Extended precision is not offered in SIMD form.
// - Dual extended access moves two words in parallel into primary element.
// - Broadcast load is a hybrid of single-path and SIMD routing.
// - Dual broadcast extended and long-word loads use their own routing.
// - Mixed-width transfer is always dual-data over both buses.
// - Each bus picks its own word type with the common mode.
// - Long word on data bus runs with short word on program bus.
// - Long word on data bus runs with extended word on program bus.
// - Plain normal word uses the lower 32-bit lane, unused lanes zero.
// - Plain normal word loads zero eight low bits, stores drop them.
// - Short word uses four 16-bit lanes, explicit value in lowest.
// - SIMD implicit word goes to the complement register in other element.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
module mbl_lane_steer
#(
   parameter int NUM_REGS = 16
)
(
   input  wire logic                             ref_clk,
   input  wire logic                             rst,
   input  wire logic                             s_axi_awvalid,
   output logic                                  s_axi_awready,
   input  wire logic [mbl_pkg::MBL_AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                             s_axi_wvalid,
   output logic                                  s_axi_wready,
   input  wire logic [31:0]                      s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   output logic                                  s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   output logic [1:0]                            s_axi_bresp,
   input  wire logic                             s_axi_arvalid,
   output logic                                  s_axi_arready,
   input  wire logic [mbl_pkg::MBL_AXI_AW-1:0]   s_axi_araddr,
   output logic                                  s_axi_rvalid,
   input  wire logic                             s_axi_rready,
   output logic [31:0]                           s_axi_rdata,
   output logic [1:0]                            s_axi_rresp,
   input  wire logic                             cmdValid,
   output logic                                  cmdReady,
   input  wire mbl_pkg::mbl_cmd_s                cmd,
   input  wire logic [mbl_pkg::MBL_BUS_W-1:0]    pmRdData,
   input  wire logic [mbl_pkg::MBL_BUS_W-1:0]    dmRdData,
   output logic [mbl_pkg::MBL_BUS_W-1:0]         pmWrData,
   output logic [mbl_pkg::MBL_BUS_W-1:0]         dmWrData,
   output logic                                  pmWrStb,
   output logic                                  dmWrStb
);
   import mbl_pkg::*;

   if (NUM_REGS != (1 << MBL_IDX_W))
   begin : gChk
      $error("NUM_REGS must equal two to the power of the index width.");
   end

   logic [MBL_REG_W-1:0]  rf [2][NUM_REGS];
   mbl_mode_e             mode;
   logic                  enable;
   logic                  extSimdSeen;
   logic                  conflictSeen;
   logic [31:0]           accCount;
   logic                  selPe;
   logic [MBL_IDX_W-1:0]  selIdx;
   logic                  awHeld;
   logic                  wHeld;
   logic [MBL_AXI_AW-1:0] awAddr;
   logic [31:0]           wData;
   logic [3:0]            wStrb;
   logic                  wrFire;
   logic [31:0]           wMask;
   logic                  accept;
   logic [1:0]            act;
   logic                  busSimd;
   logic                  extSimd;
   logic                  conflict;
   mbl_side_s             side [2];
   mbl_mode_e             busMode [2];
   mbl_load_s             ld [2];
   logic [MBL_BUS_W-1:0]  packed_ [2];
   logic [MBL_IDX_W-1:0]  nbIdx [2];
   logic [MBL_REG_W-1:0]  selReg;

   assign cmdReady = enable;
   assign accept   = cmdValid & cmdReady;
   assign busSimd  = (mode == MBL_SIMD);
   assign side[0]  = cmd.pm;
   assign side[1]  = cmd.dm;
   assign selReg   = rf[selPe][selIdx];

   // A mixed-width pair only exists as a dual access; a single access drives one bus.
   assign act[0] = accept & (cmd.dual | ~cmd.useDm);
   assign act[1] = accept & (cmd.dual | cmd.useDm);

   assign extSimd = ((act[0] & (cmd.pm.wtype == MBL_EXT)) |
                     (act[1] & (cmd.dm.wtype == MBL_EXT))) & busSimd;

   // Same register named by both buses, or a long-word pair overlapping the other target.
   assign conflict = accept & cmd.dual & ~cmd.store & (cmd.pm.pe == cmd.dm.pe) &
                     ((cmd.pm.idx == cmd.dm.idx) |
                      (((cmd.pm.wtype == MBL_LW) | (cmd.dm.wtype == MBL_LW)) &
                       (cmd.pm.idx[MBL_IDX_W-1:1] == cmd.dm.idx[MBL_IDX_W-1:1])));

   for (genvar b = 0; b < 2; b++)
   begin : gBus
      logic [MBL_BUS_W-1:0] rdBus;

      assign rdBus    = (b == 0) ? pmRdData : dmRdData;
      assign nbIdx[b] = side[b].idx ^ {{(MBL_IDX_W-1){1'b0}}, 1'b1};
      // Extended words fall back to single-path routing when SIMD is selected.
      assign busMode[b] = (side[b].wtype == MBL_EXT && mode == MBL_SIMD) ?
                          MBL_SINGLE_DATA_PATH_MODE : mode;

      mbl_lane_unpack uUnpack
      (
         .bus   (rdBus),
         .wtype (side[b].wtype),
         .mode  (busMode[b]),
         .ld    (ld[b])
      );

      mbl_lane_pack uPack
      (
         .named (rf[side[b].pe][side[b].idx]),
         .neigh (rf[side[b].pe][nbIdx[b]]),
         .compl (rf[~side[b].pe][side[b].idx]),
         .wtype (side[b].wtype),
         .simd  (busMode[b] == MBL_SIMD),
         .bus   (packed_[b])
      );
   end

   // Loads from both buses land in the same cycle; data bus writes win a collision.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int p = 0; p < 2; p++)
         begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
               rf[p][i] <= '0;
            end
         end
      end
      else
      begin
         if (wrFire && awAddr == MBL_RFLO_OFS)
         begin
            rf[selPe][selIdx][31:0] <= (selReg[31:0] & ~wMask) | (wData & wMask);
         end
         if (wrFire && awAddr == MBL_RFHI_OFS && wStrb[0])
         begin
            rf[selPe][selIdx][MBL_REG_W-1:32] <= wData[MBL_REG_W-33:0];
         end
         for (int b = 0; b < 2; b++)
         begin
            if (act[b] && !cmd.store)
            begin
               // The neighbor is the other register of the even/odd pair.
               if (ld[b].en[0])
                  rf[side[b].pe][side[b].idx] <= ld[b].named;
               if (ld[b].en[1])
                  rf[side[b].pe][nbIdx[b]] <= ld[b].neigh;
               if (ld[b].en[2])
                  rf[~side[b].pe][side[b].idx] <= ld[b].compl;
               if (ld[b].en[3])
                  rf[~side[b].pe][nbIdx[b]] <= ld[b].complNeigh;
            end
         end
      end
   end

   // Both buses are driven in the same cycle, so mixed pairs run in parallel.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pmWrData <= '0;
         dmWrData <= '0;
         pmWrStb  <= 1'b0;
         dmWrStb  <= 1'b0;
      end
      else
      begin
         pmWrStb <= act[0] & cmd.store;
         dmWrStb <= act[1] & cmd.store;
         if (act[0] && cmd.store)
            pmWrData <= packed_[0];
         if (act[1] && cmd.store)
            dmWrData <= packed_[1];
      end
   end

   // Sticky status; an event in the clearing cycle stays set.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         extSimdSeen  <= 1'b0;
         conflictSeen <= 1'b0;
      end
      else
      begin
         if (wrFire && awAddr == MBL_STAT_OFS && wStrb[0])
         begin
            if (wData[MBL_STAT_EXT_BIT])
               extSimdSeen <= 1'b0;
            if (wData[MBL_STAT_CONF_BIT])
               conflictSeen <= 1'b0;
         end
         if (extSimd)
            extSimdSeen <= 1'b1;
         if (conflict)
            conflictSeen <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         accCount <= '0;
      else if (accept)
         accCount <= accCount + 32'h0000_0001;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         mode   <= mbl_mode_e'(MBL_MODE_RST);
         enable <= MBL_EN_RST;
         selPe  <= 1'b0;
         selIdx <= '0;
      end
      else if (wrFire && wStrb[0])
      begin
         if (awAddr == MBL_CTRL_OFS)
         begin
            // The unused mode code reads back as single-path.
            mode   <= (wData[1:0] == 2'b11) ? MBL_SINGLE_DATA_PATH_MODE : mbl_mode_e'(wData[1:0]);
            enable <= wData[MBL_CTRL_EN_BIT];
         end
         if (awAddr == MBL_SEL_OFS)
         begin
            selIdx <= wData[MBL_IDX_W-1:0];
            selPe  <= wData[MBL_SEL_PE_BIT];
         end
      end
   end

   // Register bus slave: address and data are held until both have arrived.
   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wrFire        = awHeld & wHeld & ~s_axi_bvalid;

   always_comb
   begin
      for (int k = 0; k < 4; k++)
      begin
         wMask[8*k +: 8] = {8{wStrb[k]}};
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         awHeld <= 1'b0;
         wHeld  <= 1'b0;
         awAddr <= '0;
         wData  <= '0;
         wStrb  <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         else if (wrFire)
            awHeld <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         else if (wrFire)
            wHeld <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= MBL_RESP_OK;
      end
      else if (wrFire)
      begin
         s_axi_bvalid <= 1'b1;
         case (awAddr)
            MBL_CTRL_OFS, MBL_STAT_OFS, MBL_SEL_OFS, MBL_RFLO_OFS, MBL_RFHI_OFS:
               s_axi_bresp <= MBL_RESP_OK;
            default:
               s_axi_bresp <= MBL_RESP_ERR;
         endcase
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= MBL_RESP_OK;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= MBL_RESP_OK;
         s_axi_rdata  <= '0;
         case (s_axi_araddr)
            MBL_CTRL_OFS:
               s_axi_rdata <= {29'h0, enable, mode};
            MBL_STAT_OFS:
               s_axi_rdata <= {30'h0, conflictSeen, extSimdSeen};
            MBL_CNT_OFS:
               s_axi_rdata <= accCount;
            MBL_SEL_OFS:
               s_axi_rdata <= {27'h0, selPe, selIdx};
            MBL_RFLO_OFS:
               s_axi_rdata <= selReg[31:0];
            MBL_RFHI_OFS:
               s_axi_rdata <= {24'h0, selReg[MBL_REG_W-1:32]};
            default:
               s_axi_rresp <= MBL_RESP_ERR;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

/* verif/mbl_mem_model.sv */
// Behavioural model of the two internal memory blocks behind the data buses.
`timescale 1ns/1ns
module mbl_mem_model
(
   input  wire logic        ref_clk,
   input  wire logic        rdEn,
   input  wire logic        addr,
   input  wire logic        pmWrStb,
   input  wire logic        dmWrStb,
   input  wire logic [63:0] pmWrData,
   input  wire logic [63:0] dmWrData,
   output logic      [63:0] pmRdData,
   output logic      [63:0] dmRdData
);
   logic [63:0] pmMem [2];
   logic [63:0] dmMem [2];
   logic [63:0] noise = 64'h0000_0000_0000_0000;

   // Outside a read the buses carry a moving pattern, so stale data never passes for a word.
   assign pmRdData = rdEn ? pmMem[addr] : noise;
   assign dmRdData = rdEn ? dmMem[addr] : ~noise;

   always @(posedge ref_clk)
   begin
      noise <= {noise[62:0], ~noise[63]};
      if (pmWrStb)
         pmMem[addr] <= pmWrData;
      if (dmWrStb)
         dmMem[addr] <= dmWrData;
   end
endmodule

/* verif/mbl_lane_steer_sva.sv */
// Concurrent checks on the store side of the lane steering block.
`timescale 1ns/1ns
module mbl_lane_steer_sva
(
   input wire logic                           ref_clk,
   input wire logic                           rst,
   input wire logic                           cmdValid,
   input wire logic                           cmdReady,
   input wire mbl_pkg::mbl_cmd_s              cmd,
   input wire logic [mbl_pkg::MBL_BUS_W-1:0]  pmWrData,
   input wire logic [mbl_pkg::MBL_BUS_W-1:0]  dmWrData,
   input wire logic                           pmWrStb,
   input wire logic                           dmWrStb
);
   import mbl_pkg::*;
   logic pmSt;
   logic dmSt;

   assign pmSt = cmdValid && cmdReady && cmd.store && (cmd.dual || !cmd.useDm);
   assign dmSt = cmdValid && cmdReady && cmd.store && (cmd.dual || cmd.useDm);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property p_pm_stb;
      1'b1 |=> pmWrStb == $past(pmSt);
   endproperty
   a_pm_stb: assert property (p_pm_stb) else $error("program bus strobe wrong");
   property p_dm_stb;
      dmSt |=> dmWrStb;
   endproperty
   a_dm_stb: assert property (p_dm_stb) else $error("data bus strobe missing");
   property p_dual;
      cmdValid && cmdReady && cmd.store && cmd.dual |=> pmWrStb && dmWrStb;
   endproperty
   a_dual: assert property (p_dual) else $error("dual store not on both buses");
   property p_pm_ext;
      pmSt && cmd.pm.wtype == MBL_EXT |=> pmWrData[23:0] == 24'h00_0000;
   endproperty
   a_pm_ext: assert property (p_pm_ext) else $error("extended store low bits set");
   property p_dm_ext;
      dmSt && cmd.dm.wtype == MBL_EXT |=> dmWrData[23:0] == 24'h00_0000;
   endproperty
   a_dm_ext: assert property (p_dm_ext) else $error("extended store low bits set");
   property p_pm_sw;
      pmSt && cmd.pm.wtype == MBL_SW |=> pmWrData[63:48] == 16'h0000
         && pmWrData[31:16] == 16'h0000;
   endproperty
   a_pm_sw: assert property (p_pm_sw) else $error("short store lanes not zero");
   property p_hold;
      pmWrStb ##1 !pmWrStb |-> $stable(pmWrData);
   endproperty
   a_hold: assert property (p_hold) else $error("store data moved without store");
   property p_mix;
      dmSt && pmSt && cmd.dm.wtype == MBL_LW && cmd.pm.wtype == MBL_EXT
         |=> dmWrStb && pmWrStb && pmWrData[23:0] == 24'h00_0000;
   endproperty
   a_mix: assert property (p_mix) else $error("mixed store wrong");
endmodule

bind mbl_lane_steer mbl_lane_steer_sva u_sva
(
   .ref_clk,
   .rst,
   .cmdValid,
   .cmdReady,
   .cmd,
   .pmWrData,
   .dmWrData,
   .pmWrStb,
   .dmWrStb
);

/* verif/tb_top.sv */
// Self-checking bench: load and store round trips through every word type and mode.
`timescale 1ns/1ns
module tb_top;
   import mbl_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmdValid = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   mbl_cmd_s    cmd = '0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        cmdReady, pmWrStb, dmWrStb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, q, seed = 32'h0000_9EC0;
   logic [63:0] pmRdData, dmRdData, pmWrData, dmWrData, pmB, dmB;
   logic [1:0]  r;
   mbl_cmd_s    c;
   int          failures = 0, num_checks = 0;

   always #20 ref_clk = ~ref_clk;

   mbl_lane_steer #(.NUM_REGS(16)) dut (.ref_clk, .rst, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cmdValid,
      .cmdReady, .cmd, .pmRdData, .dmRdData, .pmWrData, .dmWrData, .pmWrStb, .dmWrStb);
   mbl_mem_model mem (.ref_clk, .rdEn(cmdValid && !cmd.store), .addr(cmd.store), .pmWrStb,
      .dmWrStb, .pmWrData, .dmWrData, .pmRdData, .dmRdData);

   function automatic logic [31:0] lfsr();
      seed = (seed >> 1) ^ (seed[0] ? 32'h8020_0003 : 32'h0000_0000);
      return seed;
   endfunction

   function automatic logic [63:0] exp_rt(mbl_wtype_e t, bit simd, logic [63:0] b);
      case (t)
         MBL_LW:  return b;
         MBL_EXT: return {b[63:24], 24'h00_0000};
         MBL_N32: return simd ? b : {32'h0000_0000, b[31:0]};
         default: return simd ? {16'h0000, b[47:32], 16'h0000, b[15:0]}
                              : {48'h0000_0000_0000, b[15:0]};
      endcase
   endfunction

   function automatic logic [31:0] exp_lo(mbl_wtype_e t, logic [63:0] b);
      case (t)
         MBL_EXT: return b[55:24];
         MBL_SW:  return {8'h00, b[15:0], 8'h00};
         default: return {b[23:0], 8'h00};
      endcase
   endfunction

   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bound(input logic ok);
      if (ok !== 1'b1)
      begin
         failures++;
         report_and_stop();
      end
   endtask

   // Every bus task starts and ends just after a rising edge.
   task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      bit done, aTk, wTk, rTk;
      n = 0;
      done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      while (!done && n < 50)
      begin
         @(negedge ref_clk);
         n++;
         done = wr ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         r = wr ? s_axi_bresp : s_axi_rresp;
         aTk = s_axi_awvalid && s_axi_awready;
         wTk = s_axi_wvalid && s_axi_wready;
         rTk = s_axi_arvalid && s_axi_arready;
         @(posedge ref_clk);
         if (aTk)
            s_axi_awvalid <= 1'b0;
         if (wTk)
            s_axi_wvalid <= 1'b0;
         if (rTk)
            s_axi_arvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      // One edge passes so that a following call never reassigns a handshake in this step.
      @(posedge ref_clk);
      bound(done);
   endtask

   task automatic send(input mbl_cmd_s cc);
      int n;
      logic tk;
      n = 0;
      tk = 1'b0;
      cmd <= cc;
      cmdValid <= 1'b1;
      while (!tk && n < 50)
      begin
         @(negedge ref_clk);
         n++;
         tk = cmdReady;
         @(posedge ref_clk);
      end
      cmdValid <= 1'b0;
      bound(tk);
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      axi(1'b0, MBL_CTRL_OFS, 32'h0000_0000);
      chk(q, 32'h0000_0004);
      axi(1'b0, 8'h40, 32'h0000_0000);
      chk(r, MBL_RESP_ERR);
      for (int m = 0; m < 3; m++)
         for (int t = 0; t < 4; t++)
         begin
            axi(1'b1, MBL_CTRL_OFS, 32'h0000_0004 | 32'(m));
            chk(r, MBL_RESP_OK);
            pmB = {lfsr(), lfsr()};
            // An all-ones word shows most clearly whether the low register byte is cleared.
            dmB = (t == 3) ? 64'hFFFF_FFFF_FFFF_FFFF : {lfsr(), lfsr()};
            mem.pmMem[0] = pmB;
            mem.dmMem[0] = dmB;
            c = '0;
            c.dual = 1'b1;
            c.pm = '{1'b0, 4'h2, mbl_wtype_e'(t)};
            c.dm = '{1'b0, 4'h8, MBL_LW};
            send(c);
            axi(1'b1, MBL_SEL_OFS, 32'h0000_0002);
            axi(1'b0, MBL_RFLO_OFS, 32'h0000_0000);
            chk(q, exp_lo(mbl_wtype_e'(t), pmB));
            axi(1'b1, MBL_SEL_OFS, (m == 2) ? 32'h0000_0019 : 32'h0000_0009);
            axi(1'b0, MBL_RFLO_OFS, 32'h0000_0000);
            chk(q, {dmB[55:32], 8'h00});
            c.store = 1'b1;
            send(c);
            @(negedge ref_clk);
            chk({pmWrStb, dmWrStb}, 2'b11);
            chk(pmWrData, exp_rt(mbl_wtype_e'(t), m == 1, pmB));
            chk(dmWrData, dmB);
            @(posedge ref_clk);
            if (m == 2 && t == 2)
            begin
               axi(1'b1, MBL_CTRL_OFS, 32'h0000_0005);
               c.dual = 1'b0;
               send(c);
               @(negedge ref_clk);
               chk(pmWrData, {pmB[31:0], pmB[31:0]});
               @(posedge ref_clk);
            end
         end
      // Single extended store on the data bus from the all-ones long-word load.
      c.dual = 1'b0;
      c.useDm = 1'b1;
      c.dm.wtype = MBL_EXT;
      send(c);
      @(negedge ref_clk);
      chk(dmWrData, 64'hFFFF_FFFF_0000_0000);
      @(posedge ref_clk);
      axi(1'b0, MBL_STAT_OFS, 32'h0000_0000);
      chk(q, 32'h0000_0001);
      axi(1'b0, MBL_CNT_OFS, 32'h0000_0000);
      chk(q, 32'h0000_001A);
      axi(1'b1, MBL_CTRL_OFS, 32'h0000_0000);
      @(negedge ref_clk);
      chk(cmdReady, 1'b0);
      @(posedge ref_clk);
      report_and_stop();
   end
endmodule
